/* rtl/utfa_regs.sv */
`timescale 1ns/10ps
`include "utfa_cfg.svh"

module utfa_regs
	import utfa_pkg::*;
#(
	parameter int FRAME_W = `UTFA_FRAME_W,
	parameter int ADDR_W  = `UTFA_ADDR_W
)
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Processor side: one index port and one data port.
	input  wire logic              cpu_wr,
	input  wire logic              cpu_rd,
	input  wire logic              cpu_port_sel,
	input  wire logic [7:0]        cpu_wdata,
	output logic      [7:0]        cpu_rdata,
	output logic                   cpu_rvalid,
	// Link side from the serial engine.
	input  wire logic              sof_valid,
	input  wire logic [FRAME_W-1:0] sof_frame,
	input  wire logic              token_valid,
	input  wire logic [ADDR_W-1:0] token_addr,
	input  wire logic [3:0]        token_ep,
	input  wire logic              token_dir_in,
	output logic                   token_accept,
	output logic                   token_ep_ok,
	output logic                   token_hit,
	output logic      [1:0]        token_hit_ep,
	output logic                   token_hit_in,
	input  wire logic              addr_load,
	input  wire logic [ADDR_W-1:0] addr_value,
	input  wire logic              ack_done,
	input  wire logic              ack_dir_in,
	input  wire logic [1:0]        ack_ep,
	input  wire logic              data_pid_valid,
	input  wire logic              data_pid_one,
	input  wire logic              data_pid_in,
	input  wire logic [1:0]        data_pid_ep,
	output logic                   data_seq_ok,
	output logic      [3:0]        toggle_in,
	output logic      [3:0]        toggle_out,
	output logic      [FRAME_W-1:0] frame_number,
	output logic                   sof_seen
);

	utfa_tog_if tog ();

	// Stored state.
	logic [7:0]         sub_index;
	utfa_dir_t          dir_sel;
	utfa_ep_t           ep_sel;
	logic [FRAME_W-1:0] frame_count;
	logic [ADDR_W-1:0]  dev_addr;

	// Decoded accesses.
	logic idx_write;
	logic data_write;
	logic data_read;
	logic idx_read;
	logic hit_toggle;
	logic hit_frame_low;
	logic hit_frame_high;
	logic hit_addr;
	logic toggle_write;
	logic sel_toggle;
	logic addr_match;
	logic ep_in_range;

	// Read path.
	logic [7:0] toggle_byte;
	logic [7:0] frame_low_byte;
	logic [7:0] frame_high_byte;
	logic [7:0] addr_byte;
	logic [7:0] data_mux;
	logic [7:0] read_mux;

	// Next values.
	utfa_dir_t          next_dir_sel;
	utfa_ep_t           next_ep_sel;
	logic [FRAME_W-1:0] next_frame_count;
	logic [ADDR_W-1:0]  next_dev_addr;
	logic [7:0]         next_sub_index;

	// Port decode: the index port steers every data port access.
	assign idx_write  = cpu_wr & (cpu_port_sel == UTFA_PORT_INDEX);
	assign idx_read   = cpu_rd & (cpu_port_sel == UTFA_PORT_INDEX);
	assign data_write = cpu_wr & (cpu_port_sel == UTFA_PORT_DATA);
	assign data_read  = cpu_rd & (cpu_port_sel == UTFA_PORT_DATA);

	// Subregister decode from the index.
	assign hit_toggle     = (sub_index == `UTFA_IDX_TOGGLE_CTL);
	assign hit_frame_low  = (sub_index == `UTFA_IDX_FRAME_LOW);
	assign hit_frame_high = (sub_index == `UTFA_IDX_FRAME_HIGH);
	assign hit_addr       = (sub_index == `UTFA_IDX_DEV_ADDR);
	assign toggle_write   = data_write & hit_toggle;

	// The selection written in the same access is used by its forcing bits,
	// so a single write can both select and force.
	assign next_dir_sel = toggle_write ? utfa_dir_t'(cpu_wdata[`UTFA_DIR_SEL_BIT])
		: dir_sel;
	assign next_ep_sel  = toggle_write
		? cpu_wdata[`UTFA_EP_SEL_MSB:`UTFA_EP_SEL_LSB] : ep_sel;

	// Forcing strobes go to the bank for one cycle only and are never stored.
	assign tog.sel_dir    = next_dir_sel;
	assign tog.sel_ep     = next_ep_sel;
	assign tog.force_one  = toggle_write & cpu_wdata[`UTFA_FORCE_ONE_BIT];
	assign tog.force_zero = toggle_write & cpu_wdata[`UTFA_FORCE_ZERO_BIT];

	// Acknowledged transactions flip the toggle of their endpoint.
	assign tog.ack_pulse = ack_done;
	assign tog.ack_dir   = utfa_dir_t'(ack_dir_in);
	assign tog.ack_ep    = ack_ep;

	utfa_toggle_bank u_bank
	(
		.clock   (clock),
		.sys_rst (sys_rst),
		.tog     (tog.bank)
	);

	// Current toggle of the stored selection.
	assign sel_toggle = tog.tog_vec[utfa_tog_idx(dir_sel, ep_sel)];

	// Register images; reserved and strobe bits read as zero.
	assign toggle_byte = {sel_toggle, 2'h0, dir_sel, 2'h0, ep_sel};
	assign frame_low_byte  = frame_count[`UTFA_FRAME_LOW_W-1:0];
	assign frame_high_byte = {5'h00, frame_count[FRAME_W-1:`UTFA_FRAME_LOW_W]};
	assign addr_byte       = {1'h0, dev_addr};

	// Data port selection; unknown subregisters read as zero.
	assign data_mux = hit_toggle ? toggle_byte
		: hit_frame_low ? frame_low_byte
		: hit_frame_high ? frame_high_byte
		: hit_addr ? addr_byte
		: `UTFA_RST_BYTE;
	assign read_mux = idx_read ? sub_index : data_mux;

	// Index register.
	assign next_sub_index = idx_write ? cpu_wdata : sub_index;

	// Frame number taken from each start-of-frame packet.
	assign next_frame_count = sof_valid ? sof_frame : frame_count;

	// Address is loaded by the control logic that handles the host's assignment.
	assign next_dev_addr = addr_load ? addr_value : dev_addr;

	// Processor-visible registers.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sub_index <= `UTFA_RST_BYTE;
			dir_sel   <= UTFA_DIR_OUT;
			ep_sel    <= 2'h0;
		end
		else
		begin
			sub_index <= next_sub_index;
			dir_sel   <= next_dir_sel;
			ep_sel    <= next_ep_sel;
		end
	end

	// Frame count and device address, both cleared by reset.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			frame_count <= `UTFA_RST_FRAME;
			dev_addr    <= `UTFA_RST_ADDR;
		end
		else
		begin
			frame_count <= next_frame_count;
			dev_addr    <= next_dev_addr;
		end
	end

	// Read data is presented one cycle after the read strobe.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cpu_rdata  <= `UTFA_RST_BYTE;
			cpu_rvalid <= 1'b0;
		end
		else
		begin
			cpu_rvalid <= cpu_rd;
			if (cpu_rd)
				cpu_rdata <= read_mux;
		end
	end

	// Token filter: only the stored address is answered.
	assign addr_match   = (token_addr == dev_addr);
	assign ep_in_range  = (token_ep[3:2] == 2'h0);
	assign token_accept = token_valid & addr_match;
	assign token_ep_ok  = token_accept & ep_in_range;

	// Endpoint and direction of an accepted token for endpoints 0 to 3 held for the data stage.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			token_hit    <= 1'b0;
			token_hit_ep <= 2'h0;
			token_hit_in <= 1'b0;
		end
		else
		begin
			token_hit <= token_ep_ok;
			if (token_ep_ok)
			begin
				token_hit_ep <= token_ep[1:0];
				token_hit_in <= token_dir_in;
			end
		end
	end

	// Checks a received data PID against the expected toggle of its endpoint;
	// a mismatch marks a repeated packet that must be acknowledged but dropped.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			data_seq_ok <= 1'b0;
		else if (data_pid_valid)
			data_seq_ok <= data_pid_one ==
				tog.tog_vec[utfa_tog_idx(utfa_dir_t'(data_pid_in), data_pid_ep)];
	end

	// Toggle, frame and start-of-frame indications for the serial engine.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			toggle_in    <= 4'h0;
			toggle_out   <= 4'h0;
			frame_number <= `UTFA_RST_FRAME;
			sof_seen     <= 1'b0;
		end
		else
		begin
			toggle_in    <= tog.tog_vec[7:4];
			toggle_out   <= tog.tog_vec[3:0];
			frame_number <= next_frame_count;
			sof_seen     <= sof_valid;
		end
	end

endmodule

/* rtl/utfa_cfg.svh */
`ifndef UTFA_CFG_SVH
`define UTFA_CFG_SVH

// Subregister codes loaded into the index before the data port is used.
`define UTFA_IDX_TOGGLE_CTL   8'h57
`define UTFA_IDX_FRAME_LOW    8'h58
`define UTFA_IDX_FRAME_HIGH   8'h59
`define UTFA_IDX_DEV_ADDR     8'h5B

// Field positions in the endpoint toggle control register.
`define UTFA_TOG_VALUE_BIT    7
`define UTFA_FORCE_ONE_BIT    6
`define UTFA_FORCE_ZERO_BIT   5
`define UTFA_DIR_SEL_BIT      4
`define UTFA_EP_SEL_MSB       1
`define UTFA_EP_SEL_LSB       0

// Widths of the stored values.
`define UTFA_FRAME_W          11
`define UTFA_FRAME_LOW_W      8
`define UTFA_FRAME_HIGH_W     3
`define UTFA_ADDR_W           7

// Reset values.
`define UTFA_RST_BYTE         8'h00
`define UTFA_RST_FRAME        11'h000
`define UTFA_RST_ADDR         7'h00
`define UTFA_RST_TOGGLES      8'h00

`endif

/* rtl/utfa_pkg.sv */
package utfa_pkg;

	// Direction of an endpoint as coded in the direction select bit.
	typedef enum logic
	{
		UTFA_DIR_OUT = 1'b0,
		UTFA_DIR_IN  = 1'b1
	} utfa_dir_t;

	// Endpoint number, four endpoints.
	typedef logic [1:0] utfa_ep_t;

	// Flat index of one toggle bit: direction is the upper bit.
	typedef logic [2:0] utfa_tog_idx_t;

	// Port selected by the processor: index or data.
	typedef enum logic
	{
		UTFA_PORT_INDEX = 1'b0,
		UTFA_PORT_DATA  = 1'b1
	} utfa_port_t;

	// Builds the toggle index from direction and endpoint number.
	function automatic utfa_tog_idx_t utfa_tog_idx(input utfa_dir_t dir, input utfa_ep_t ep);
		utfa_tog_idx = {dir, ep};
	endfunction

endpackage

/* rtl/utfa_tog_if.sv */
`timescale 1ns/10ps

// Carries selection, forcing strobes and acknowledge events to the toggle bank.
interface utfa_tog_if;
	import utfa_pkg::*;

	utfa_dir_t  sel_dir;
	utfa_ep_t   sel_ep;
	logic       force_one;
	logic       force_zero;
	logic       ack_pulse;
	utfa_dir_t  ack_dir;
	utfa_ep_t   ack_ep;
	logic [7:0] tog_vec;

	modport ctrl (output sel_dir, output sel_ep, output force_one, output force_zero,
		output ack_pulse, output ack_dir, output ack_ep, input tog_vec);
	modport bank (input sel_dir, input sel_ep, input force_one, input force_zero,
		input ack_pulse, input ack_dir, input ack_ep, output tog_vec);
endinterface

/* rtl/utfa_toggle_bank.sv */
`timescale 1ns/10ps
`include "utfa_cfg.svh"

// Holds one data toggle per endpoint and direction.
module utfa_toggle_bank
	import utfa_pkg::*;
(
	input  wire logic clock,
	input  wire logic sys_rst,
	utfa_tog_if.bank  tog
);

	logic [7:0]    toggles;
	logic [7:0]    next_toggles;
	utfa_tog_idx_t sel_idx;
	utfa_tog_idx_t ack_idx;

	assign sel_idx = utfa_tog_idx(tog.sel_dir, tog.sel_ep);
	assign ack_idx = utfa_tog_idx(tog.ack_dir, tog.ack_ep);

	// A forcing write wins over an acknowledge flip on the same endpoint,
	// so software always sees the value it forced.
	always_comb
	begin
		next_toggles = toggles;
		if (tog.ack_pulse)
			next_toggles[ack_idx] = ~toggles[ack_idx];
		if (tog.force_one)
			next_toggles[sel_idx] = 1'b1;
		else if (tog.force_zero)
			next_toggles[sel_idx] = 1'b0;
	end

	// Toggle storage.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			toggles <= `UTFA_RST_TOGGLES;
		else
			toggles <= next_toggles;
	end

	assign tog.tog_vec = toggles;

endmodule

/* test/utfa_regs_chk.sv */
`timescale 1ns/10ps

// Checks answer timing, the address filter, toggle updates and zero bits.
module utfa_regs_chk
#(
	parameter int ADDR_W = 7
)
(
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire logic              cpu_wr,
	input wire logic              cpu_rd,
	input wire logic              cpu_port_sel,
	input wire logic [7:0]        cpu_wdata,
	input wire logic [7:0]        cpu_rdata,
	input wire logic              cpu_rvalid,
	input wire logic              token_valid,
	input wire logic [ADDR_W-1:0] token_addr,
	input wire logic [3:0]        token_ep,
	input wire logic              token_ep_ok,
	input wire logic              token_accept,
	input wire logic              addr_load,
	input wire logic [ADDR_W-1:0] addr_value,
	input wire logic              ack_done,
	input wire logic              ack_dir_in,
	input wire logic [1:0]        ack_ep,
	input wire logic [3:0]        toggle_in,
	input wire logic [3:0]        toggle_out
);
	logic [7:0]        idx;
	logic [ADDR_W-1:0] dev_addr;
	wire  [7:0]        tog = {toggle_in, toggle_out};
	wire  [2:0]        wsel = {cpu_wdata[4], cpu_wdata[1:0]};
	wire               rd_dat = cpu_rd && cpu_port_sel;
	wire               wr_tog = cpu_wr && cpu_port_sel && idx == 8'h57;

	// Mirrors the subregister index and the stored device address.
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			{idx, dev_addr} <= '0;
		else
		begin
			idx      <= (cpu_wr && !cpu_port_sel) ? cpu_wdata : idx;
			dev_addr <= addr_load ? addr_value : dev_addr;
		end

	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_ack;
		ack_done && !cpu_wr;
	endsequence
	sequence s_one;
		wr_tog && cpu_wdata[6];
	endsequence
	sequence s_zero;
		wr_tog && cpu_wdata[5] && !cpu_wdata[6];
	endsequence

	property p_rvalid;
		cpu_rd |=> cpu_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_accept;
		token_accept == (token_valid && token_addr == dev_addr);
	endproperty
	a_accept: assert property (p_accept) else $error("address filter wrong");
	property p_epok;
		token_ep_ok == (token_accept && token_ep[3:2] == 2'b00);
	endproperty
	a_epok: assert property (p_epok) else $error("endpoint range filter wrong");
	property p_ack;
		s_ack |=> ##1 (tog ^ $past(tog)) == (8'h01 << {$past(ack_dir_in, 2), $past(ack_ep, 2)});
	endproperty
	a_ack: assert property (p_ack) else $error("toggle did not flip alone");
	property p_one;
		s_one |=> ##1 tog[$past(wsel, 2)];
	endproperty
	a_one: assert property (p_one) else $error("toggle not forced to one");
	property p_zero;
		s_zero |=> ##1 !tog[$past(wsel, 2)];
	endproperty
	a_zero: assert property (p_zero) else $error("toggle not forced to zero");
	property p_rsvd;
		rd_dat && idx == 8'h57 |=> cpu_rdata[6:5] == 2'b00 && cpu_rdata[3:2] == 2'b00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("strobe or reserved bit read as one");
	property p_fhigh;
		rd_dat && idx == 8'h59 |=> cpu_rdata[7:3] == 5'h00;
	endproperty
	a_fhigh: assert property (p_fhigh) else $error("frame high upper bits set");
	property p_faddr;
		rd_dat && idx == 8'h5B |=> cpu_rdata == {1'b0, $past(dev_addr)};
	endproperty
	a_faddr: assert property (p_faddr) else $error("device address read wrong");
endmodule

bind utfa_regs utfa_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.clock, .sys_rst, .cpu_wr, .cpu_rd,
	.cpu_port_sel, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .token_valid, .token_addr, .token_accept,
	.addr_load, .addr_value, .ack_done, .ack_dir_in, .ack_ep, .toggle_in, .toggle_out, .token_ep,
	.token_ep_ok);

/* test/utfa_host_model.sv */
`timescale 1ns/10ps

// Plays the host and serial engine: frames, tokens, address setup, handshakes.
module utfa_host_model
(
	input  wire logic        clock,
	output logic             sof_valid,
	output logic      [10:0] sof_frame,
	output logic             token_valid,
	output logic      [6:0]  token_addr,
	output logic      [3:0]  token_ep,
	output logic             token_dir_in,
	output logic             addr_load,
	output logic      [6:0]  addr_value,
	output logic             ack_done,
	output logic             ack_dir_in,
	output logic      [1:0]  ack_ep
);
	// All strobes idle; released fields later carry the inverse of their last value.
	initial
		{sof_valid, sof_frame, token_valid, token_addr, token_ep, token_dir_in, addr_load,
			addr_value, ack_done, ack_dir_in, ack_ep} = '0;

	// Each event is a one-cycle strobe with its fields.
	task automatic sof(input logic [10:0] f);
		@(posedge clock) {sof_valid, sof_frame} <= {1'b1, f};
		@(posedge clock) {sof_valid, sof_frame} <= {1'b0, ~f};
	endtask
	task automatic token(input logic [6:0] a, input logic [3:0] ep, input logic din);
		@(posedge clock) {token_valid, token_addr, token_ep, token_dir_in} <= {1'b1, a, ep, din};
		@(posedge clock) {token_valid, token_addr, token_ep, token_dir_in} <= {1'b0, ~a, ~ep, ~din};
	endtask
	task automatic set_addr(input logic [6:0] a);
		@(posedge clock) {addr_load, addr_value} <= {1'b1, a};
		@(posedge clock) {addr_load, addr_value} <= {1'b0, ~a};
	endtask
	task automatic ack(input logic din, input logic [1:0] ep);
		@(posedge clock) {ack_done, ack_dir_in, ack_ep} <= {1'b1, din, ep};
		@(posedge clock) {ack_done, ack_dir_in, ack_ep} <= {1'b0, ~din, ~ep};
	endtask
endmodule

/* test/testbench.sv */
`timescale 1ns/10ps

// Drives the register port, plays the host through the model, compares answers.
module testbench;
	logic        clock;
	logic        sys_rst;
	logic        cpu_wr, cpu_rd, cpu_port_sel, cpu_rvalid;
	logic [7:0]  cpu_wdata, cpu_rdata, s;
	logic        sof_valid, token_valid, token_dir_in, token_hit;
	logic        addr_load, ack_done, ack_dir_in;
	logic [10:0] sof_frame;
	logic [6:0]  token_addr, addr_value;
	logic [3:0]  token_ep, toggle_in, toggle_out;
	logic [1:0]  token_hit_ep, ack_ep;
	wire  [7:0]  tg = {toggle_in, toggle_out};
	logic        data_pid_valid, data_pid_one, data_pid_in, data_seq_ok;
	logic        token_hit_in, sof_seen;
	logic [1:0]  data_pid_ep;
	logic [10:0] frame_number;
	int          error_cnt, tests_run, cyc;

	utfa_regs uut (.clock, .sys_rst, .cpu_wr, .cpu_rd, .cpu_port_sel, .cpu_wdata, .cpu_rdata,
		.cpu_rvalid, .sof_valid, .sof_frame, .token_valid, .token_addr, .token_ep, .token_dir_in,
		.token_accept(), .token_ep_ok(), .token_hit, .token_hit_ep, .token_hit_in, .addr_load,
		.addr_value, .ack_done, .ack_dir_in, .ack_ep, .data_pid_valid, .data_pid_one,
		.data_pid_in, .data_pid_ep, .data_seq_ok, .toggle_in, .toggle_out,
		.frame_number, .sof_seen);
	utfa_host_model host (.clock, .sof_valid, .sof_frame, .token_valid, .token_addr, .token_ep,
		.token_dir_in, .addr_load, .addr_value, .ack_done, .ack_dir_in, .ack_ep);

	// Free-running clock of 25 ns.
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Counts cycles and cuts a hang short.
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			final_report();
		end
	end

	// Compares one value and counts the comparison.
	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic final_report;
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Register port cycles: one write, one data read, and an indexed read.
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge clock) {cpu_wr, cpu_port_sel, cpu_wdata} <= {1'b1, sel, d};
		@(posedge clock) cpu_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] exp);
		@(posedge clock) {cpu_rd, cpu_port_sel} <= 2'b11;
		@(posedge clock) cpu_rd <= 1'b0;
		#1 check(cpu_rvalid, 1'b1);
		check(cpu_rdata, exp);
	endtask
	task automatic rix(input logic [7:0] i, input logic [7:0] exp);
		wr(1'b0, i);
		rd(exp);
	endtask

	// Presents one data PID and checks that a repeat is told from fresh data.
	task automatic pid(input logic din, input logic [1:0] ep, input logic one, input logic exp);
		@(posedge clock)
			{data_pid_valid, data_pid_one, data_pid_in, data_pid_ep} <= {1'b1, one, din, ep};
		@(posedge clock) data_pid_valid <= 1'b0;
		#1 check(data_seq_ok, exp);
	endtask

	// Reset, reset values, address filter, frame capture and every toggle.
	initial
	begin
		{cpu_wr, cpu_rd, cpu_port_sel, cpu_wdata} = '0;
		{data_pid_valid, data_pid_one, data_pid_in, data_pid_ep} = '0;
		{error_cnt, tests_run, cyc} = '0;
		sys_rst = 1'b1;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 5; i++)
			rix(8'h57 + i[7:0], 8'h00);
		host.set_addr(7'h7F);
		rix(8'h5B, 8'h7F);
		wr(1'b1, 8'h00);
		rd(8'h7F);
		host.token(7'h7F, 4'h3, 1'b1);
		#1 check(token_hit, 1'b1);
		check(token_hit_ep, 2'h3);
		check(token_hit_in, 1'b1);
		host.token(7'h7E, 4'h3, 1'b1);
		#1 check(token_hit, 1'b0);
		host.token(7'h7F, 4'h4, 1'b0);
		#1 check(token_hit, 1'b0);
		check(token_hit_in, 1'b1);
		host.sof(11'h5A5);
		#1 check(frame_number, 11'h5A5);
		check(sof_seen, 1'b1);
		rix(8'h58, 8'hA5);
		rix(8'h59, 8'h05);
		host.sof(11'h7FF);
		rix(8'h58, 8'hFF);
		rix(8'h59, 8'h07);
		wr(1'b0, 8'h57);
		for (int i = 0; i < 8; i++)
		begin
			s = {3'b000, i[2], 2'b00, i[1:0]};
			wr(1'b1, s | 8'h40);
			rd(s | 8'h80);
			pid(i[2], i[1:0], 1'b1, 1'b1);
			check(tg, 8'h01 << i);
			wr(1'b1, s);
			rd(s | 8'h80);
			wr(1'b1, s | 8'h20);
			rd(s);
			pid(i[2], i[1:0], 1'b1, 1'b0);
			host.ack(i[2], i[1:0]);
			rd(s | 8'h80);
			wr(1'b1, s | 8'h20);
		end
		repeat (2) @(posedge clock);
		#1 check(tg, 8'h00);
		final_report();
	end
endmodule
